/* File: can_filt_cfg.svh */
// Register map, field positions, reset values and limits of the filter/flag/mode block.
// Assumes an 8-bit register port with a 5-bit word address.
`ifndef CAN_FILT_CFG_SVH
`define CAN_FILT_CFG_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define A_CTRL0     5'h00
`define A_CTRL1     5'h01
`define A_BTR0      5'h02
`define A_BTR1      5'h03
`define A_RXFLG     5'h04
`define A_RXEN      5'h05
`define A_TXFLG     5'h06
`define A_TXEN      5'h07
`define A_FMODE     5'h08
`define A_PAT0      5'h09
`define A_MSK0      5'h0d
`define A_RXCNT     5'h11
`define A_TXCNT     5'h12

// ----------------------------------------
// Field positions
// ----------------------------------------
`define C0_SOFTRST  0
`define C0_SLPRQ    1
`define C0_SLEEP_ACK    2
`define F_RXF       0
`define F_OVR       1
`define F_BOFF      2
`define F_TERR      3
`define F_RERR      4
`define F_TWRN      5
`define F_RWRN      6
`define F_WAKE      7
`define FM_MODE_LSB 4
`define FM_HIT_LSB  0

// ----------------------------------------
// Codes, reset values and limits
// ----------------------------------------
`define FM_SINGLE   2'h0
`define FM_DUAL     2'h1
`define FM_QUAD     2'h2
`define FM_CLOSED   2'h3
`define SOFTRST_RST 1'b1
`define WARN_LIMIT  9'h060
`define PASS_LIMIT  9'h07f
`define BOFF_LIMIT  9'h0ff
`define RECESSIVE   1'b1

`endif

/* File: can_filt_pkg.sv */
// Types shared by the filter/flag/mode block and its surroundings.
// Assumes the constants header is compiled alongside.
`default_nettype none
package can_filt_pkg;

    typedef enum logic [1:0] {
        MODE_NORMAL,
        MODE_SLEEP,
        MODE_SOFT_RESET,
        MODE_POWER_DOWN
    } can_mode_t;

    typedef struct packed {
        logic        valid;
        logic [31:0] id;
    } rx_frame_t;

    typedef struct packed {
        logic [4:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } reg_req_t;

    typedef struct packed {
        logic        soft_reset_lock;
        logic        sleep_req;
        logic        sleep_ack;
        logic [7:0]  ctrl1;
        logic [7:0]  btr0;
        logic [7:0]  btr1;
        logic [1:0]  fmode;
        logic [1:0]  hit_idx;
        logic [1:0]  bg_hit;
        logic        bg_full;
        logic [31:0] pattern;
        logic [31:0] mask;
        logic [7:0]  rx_flags;
        logic [7:0]  rx_en;
        logic [2:0]  tx_empty;
        logic [2:0]  tx_en;
        logic [7:0]  rdata;
        logic [3:0]  irq;
        logic        tx_pin;
        logic        fg_copy;
        logic        core_clk_en;
        logic        reg_clk_en;
        can_mode_t   mode;
    } state_t;

endpackage
`default_nettype wire

/* File: can_filt_top.sv */
// Acceptance filter, flag/interrupt logic, protection and low-power mode control.
// Assumes a protocol engine that presents each valid frame at end of frame and
// supplies error counters, bus activity and the transmit bit.
//
// Contract
// - Incoming identifier bits match pattern bits except where mask marks don't care.
// - On a hit set receive-full and record the two-bit hit index.
// - Several matching sections report the lowest-numbered one.
// - Single mode: one 32-bit filter over full identifier and control bits.
// - Dual mode: two 16-bit filters over leading identifier and control bits.
// - Quad mode: four 8-bit filters on first eight identifier bits, hits zero to three.
// - Closed mode accepts no frame; only a frame already held in the background slot can still fill the foreground and set receive-full.
// - Four interrupt outputs from eleven sources, each with its own enable.
// - Transmit interrupt while any enabled transmit buffer is empty.
// - Receive flag and interrupt right after end of frame of accepted message.
// - Wake interrupt on bus activity only when sleep-ack and wake enable are 1.
// - Warning flags set when receive or transmit error count reaches 96.
// - Counter above 127 gives error passive and sets its passive flag.
// - Transmit counter above 255 gives bus-off and sets bus-off flag.
// - Interrupt pends while flags set; write 1 clears unless condition holds.
// - Error counters cannot be written through the register port.
// - Configuration registers accept writes only while soft-reset lock is set.
// - Transmit pin recessive in every low-power mode.
// - Sleep and soft reset stop core clocks; power-down stops all clocks.
// - CPU stop gives power-down; else sleep-ack and soft-reset pick the mode.
// - Accepted frame with both receive buffers full is dropped, overrun flag set.
`timescale 1ns/100ps
`default_nettype none
`include "can_filt_cfg.svh"

module can_filt_top #(
    parameter int ADDR_W = 5
) (
    input  wire logic                  clk_i,
    input  wire logic                  rst_i,
    input  wire can_filt_pkg::reg_req_t req_i,
    output logic [7:0]                 rd_data_o,
    input  wire can_filt_pkg::rx_frame_t frame_i,
    input  wire logic [8:0]            rx_err_cnt_i,
    input  wire logic [8:0]            tx_err_cnt_i,
    input  wire logic [2:0]            tx_done_i,
    input  wire logic                  bus_activity_i,
    input  wire logic                  bus_busy_i,
    input  wire logic                  cpu_stop_i,
    input  wire logic                  tx_bit_i,
    output logic                       bus_tx_pin_o,
    output logic                       fg_copy_o,
    output logic [1:0]                 filter_hit_index_o,
    output logic [2:0]                 tx_empty_o,
    output logic [7:0]                 ctrl1_o,
    output logic [15:0]                bit_timing_o,
    output logic                       core_clk_en_o,
    output logic                       reg_clk_en_o,
    output can_filt_pkg::can_mode_t    mode_o,
    output logic                       wake_irq_o,
    output logic                       err_irq_o,
    output logic                       rx_irq_o,
    output logic                       tx_irq_o
);
    import can_filt_pkg::*;

    // ----------------------------------------
    // Elaboration check
    // ----------------------------------------
    if (ADDR_W != 5) begin : g_bad_addr
        $error("ADDR_W must be 5");
    end

    state_t      s_ff;
    state_t      nxt_s;
    logic [3:0]  sm;
    logic [3:0]  dm;
    logic [3:0]  qm;
    logic [3:0]  hit_vec;
    logic [1:0]  hit_num;
    logic        hit_any;
    logic [7:0]  rx_clr;
    logic [2:0]  tx_clr;
    logic [7:0]  rx_cond;
    logic        wr;
    logic        rd;
    logic        rx_buffer_full;
    logic        bg;
    logic        ovr_ev;
    logic        wake_ev;
    logic [1:0]  sel;

    // ----------------------------------------
    // Filter bank
    // ----------------------------------------
    // Section k compares one byte of identifier against pattern byte k
    for (genvar k = 0; k < 4; k++) begin : g_sec
        logic [7:0] pat;
        logic [7:0] msk;
        assign pat = s_ff.pattern[31-8*k -: 8];
        assign msk = s_ff.mask[31-8*k -: 8];
        assign sm[k] = &(~((frame_i.id[31-8*k -: 8] ^ pat) & ~msk));
        assign dm[k] = &(~((frame_i.id[31-8*(k%2) -: 8] ^ pat) & ~msk));
        assign qm[k] = &(~((frame_i.id[31:24] ^ pat) & ~msk));
    end

    always_comb begin
        case (s_ff.fmode)
            `FM_SINGLE: hit_vec = {3'h0, &sm};
            `FM_DUAL:   hit_vec = {2'h0, dm[3] & dm[2], dm[1] & dm[0]};
            `FM_QUAD:   hit_vec = qm;
            default:    hit_vec = 4'h0;
        endcase
        hit_any = |hit_vec;
        if (hit_vec[0]) begin
            hit_num = 2'h0;
        end else if (hit_vec[1]) begin
            hit_num = 2'h1;
        end else if (hit_vec[2]) begin
            hit_num = 2'h2;
        end else begin
            hit_num = 2'h3;
        end
    end

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        nxt_s = s_ff;
        nxt_s.fg_copy = 1'b0;
        nxt_s.rdata = 8'h00;
        // No register access at all while powered down
        wr = req_i.wr & ~cpu_stop_i;
        rd = req_i.rd & ~cpu_stop_i;
        sel = 2'(req_i.addr - `A_PAT0);
        rx_clr = (wr && req_i.addr == `A_RXFLG) ? req_i.wdata : 8'h00;
        tx_clr = (wr && req_i.addr == `A_TXFLG) ? req_i.wdata[2:0] : 3'h0;

        if (wr) begin
            case (req_i.addr)
                `A_CTRL0: begin
                    nxt_s.soft_reset_lock = req_i.wdata[`C0_SOFTRST];
                    // Sleep request cannot be withdrawn before it is acknowledged
                    nxt_s.sleep_req = req_i.wdata[`C0_SLPRQ] | (s_ff.sleep_req & ~s_ff.sleep_ack);
                end
                `A_CTRL1: if (s_ff.soft_reset_lock) nxt_s.ctrl1 = req_i.wdata;
                `A_BTR0:  if (s_ff.soft_reset_lock) nxt_s.btr0 = req_i.wdata;
                `A_BTR1:  if (s_ff.soft_reset_lock) nxt_s.btr1 = req_i.wdata;
                `A_FMODE: begin
                    if (s_ff.soft_reset_lock) begin
                        nxt_s.fmode = req_i.wdata[`FM_MODE_LSB +: 2];
                    end
                end
                `A_RXEN:  nxt_s.rx_en = req_i.wdata;
                `A_TXEN:  nxt_s.tx_en = req_i.wdata[2:0];
                default: begin
                    if (s_ff.soft_reset_lock && req_i.addr >= `A_PAT0
                        && req_i.addr < `A_MSK0) begin
                        nxt_s.pattern[31-8*sel -: 8] = req_i.wdata;
                    end
                    if (s_ff.soft_reset_lock && req_i.addr >= `A_MSK0
                        && req_i.addr < `A_RXCNT) begin
                        nxt_s.mask[31-8*(sel ^ 2'h0) -: 8] = req_i.wdata;
                    end
                end
            endcase
        end
        // Counter offsets fall through the decode above: no write path exists

        // Error conditions from the counters
        rx_cond = 8'h00;
        rx_cond[`F_RWRN] = rx_err_cnt_i >= `WARN_LIMIT;
        rx_cond[`F_TWRN] = tx_err_cnt_i >= `WARN_LIMIT;
        rx_cond[`F_RERR] = rx_err_cnt_i > `PASS_LIMIT;
        rx_cond[`F_TERR] = tx_err_cnt_i > `PASS_LIMIT;
        rx_cond[`F_BOFF] = tx_err_cnt_i > `BOFF_LIMIT;

        // Receive path: foreground flag and background slot
        rx_buffer_full = s_ff.rx_flags[`F_RXF] & ~rx_clr[`F_RXF];
        bg = s_ff.bg_full;
        ovr_ev = 1'b0;
        if (!rx_buffer_full && bg && s_ff.mode == MODE_NORMAL) begin
            rx_buffer_full = 1'b1;
            bg = 1'b0;
            nxt_s.hit_idx = s_ff.bg_hit;
            nxt_s.fg_copy = 1'b1;
        end
        if (frame_i.valid && hit_any && s_ff.mode == MODE_NORMAL) begin
            if (!rx_buffer_full) begin
                rx_buffer_full = 1'b1;
                nxt_s.hit_idx = hit_num;
                nxt_s.fg_copy = 1'b1;
            end else if (!bg) begin
                bg = 1'b1;
                nxt_s.bg_hit = hit_num;
            end else begin
                ovr_ev = 1'b1;
            end
        end
        nxt_s.bg_full = bg;

        // Wake only counts while acknowledged asleep
        wake_ev = bus_activity_i & s_ff.sleep_ack & s_ff.rx_en[`F_WAKE];

        // Set wins over a clear in the same cycle; level flags resist clearing
        nxt_s.rx_flags = rx_cond | (s_ff.rx_flags & ~rx_clr);
        nxt_s.rx_flags[`F_RXF] = rx_buffer_full;
        nxt_s.rx_flags[`F_OVR] = ovr_ev | (s_ff.rx_flags[`F_OVR] & ~rx_clr[`F_OVR]);
        nxt_s.rx_flags[`F_WAKE] = wake_ev | (s_ff.rx_flags[`F_WAKE] & ~rx_clr[`F_WAKE]);
        nxt_s.tx_empty = tx_done_i | (s_ff.tx_empty & ~tx_clr);

        // Sleep handshake
        if (nxt_s.soft_reset_lock || !nxt_s.sleep_req || (s_ff.sleep_ack && bus_activity_i)) begin
            nxt_s.sleep_ack = 1'b0;
            if (s_ff.sleep_ack && bus_activity_i) begin
                nxt_s.sleep_req = 1'b0;
            end
        end else if (!bus_busy_i) begin
            nxt_s.sleep_ack = 1'b1;
        end

        // Mode selection
        if (cpu_stop_i) begin
            nxt_s.mode = MODE_POWER_DOWN;
        end else if (nxt_s.soft_reset_lock) begin
            nxt_s.mode = MODE_SOFT_RESET;
        end else if (nxt_s.sleep_ack) begin
            nxt_s.mode = MODE_SLEEP;
        end else begin
            nxt_s.mode = MODE_NORMAL;
        end
        nxt_s.core_clk_en = nxt_s.mode == MODE_NORMAL;
        nxt_s.reg_clk_en = nxt_s.mode != MODE_POWER_DOWN;
        nxt_s.tx_pin = (nxt_s.mode == MODE_NORMAL) ? tx_bit_i : `RECESSIVE;

        // Interrupt outputs: wake, error, receive, transmit
        nxt_s.irq[3] = nxt_s.rx_flags[`F_WAKE] & nxt_s.rx_en[`F_WAKE];
        nxt_s.irq[2] = |(nxt_s.rx_flags[6:1] & nxt_s.rx_en[6:1]);
        nxt_s.irq[1] = nxt_s.rx_flags[`F_RXF] & nxt_s.rx_en[`F_RXF];
        nxt_s.irq[0] = |(nxt_s.tx_empty & nxt_s.tx_en);

        // Read data, one cycle after the strobe
        if (rd) begin
            case (req_i.addr)
                `A_CTRL0: nxt_s.rdata = {5'h00, s_ff.sleep_ack, s_ff.sleep_req,
                                         s_ff.soft_reset_lock};
                `A_CTRL1: nxt_s.rdata = s_ff.ctrl1;
                `A_BTR0:  nxt_s.rdata = s_ff.btr0;
                `A_BTR1:  nxt_s.rdata = s_ff.btr1;
                `A_RXFLG: nxt_s.rdata = s_ff.rx_flags;
                `A_RXEN:  nxt_s.rdata = s_ff.rx_en;
                `A_TXFLG: nxt_s.rdata = {5'h00, s_ff.tx_empty};
                `A_TXEN:  nxt_s.rdata = {5'h00, s_ff.tx_en};
                `A_FMODE: nxt_s.rdata = {2'h0, s_ff.fmode, 2'h0, s_ff.hit_idx};
                `A_RXCNT: nxt_s.rdata = rx_err_cnt_i[7:0];
                `A_TXCNT: nxt_s.rdata = tx_err_cnt_i[7:0];
                default: begin
                    if (req_i.addr >= `A_PAT0 && req_i.addr < `A_MSK0) begin
                        nxt_s.rdata = s_ff.pattern[31-8*sel -: 8];
                    end else if (req_i.addr >= `A_MSK0 && req_i.addr < `A_RXCNT) begin
                        nxt_s.rdata = s_ff.mask[31-8*sel -: 8];
                    end
                end
            endcase
        end
    end

    // ----------------------------------------
    // State register
    // ----------------------------------------
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            s_ff <= '0;
            s_ff.soft_reset_lock <= `SOFTRST_RST;
            s_ff.tx_empty <= 3'h7;
            s_ff.tx_pin <= `RECESSIVE;
            s_ff.reg_clk_en <= 1'b1;
            s_ff.mode <= MODE_SOFT_RESET;
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign rd_data_o          = s_ff.rdata;
    assign bus_tx_pin_o       = s_ff.tx_pin;
    assign fg_copy_o          = s_ff.fg_copy;
    assign filter_hit_index_o = s_ff.hit_idx;
    assign tx_empty_o         = s_ff.tx_empty;
    assign ctrl1_o            = s_ff.ctrl1;
    assign bit_timing_o       = {s_ff.btr1, s_ff.btr0};
    assign core_clk_en_o      = s_ff.core_clk_en;
    assign reg_clk_en_o       = s_ff.reg_clk_en;
    assign mode_o             = s_ff.mode;
    assign wake_irq_o         = s_ff.irq[3];
    assign err_irq_o          = s_ff.irq[2];
    assign rx_irq_o           = s_ff.irq[1];
    assign tx_irq_o           = s_ff.irq[0];

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence fresh_hit_s;
        frame_i.valid && hit_any && s_ff.mode == MODE_NORMAL
            && !s_ff.rx_flags[`F_RXF] && !s_ff.bg_full;
    endsequence
    sequence both_full_hit_s;
        frame_i.valid && hit_any && s_ff.mode == MODE_NORMAL
            && s_ff.rx_flags[`F_RXF] && !rx_clr[`F_RXF] && s_ff.bg_full;
    endsequence

    hit_sets_flag_a: assert property (fresh_hit_s |=> s_ff.rx_flags[`F_RXF]
        && filter_hit_index_o == $past(hit_num) && fg_copy_o)
        else $error("hit did not fill foreground");
    lowest_hit_a: assert property (hit_vec[0] |-> hit_num == 2'h0)
        else $error("hit priority wrong");
    closed_no_rxf_a: assert property (s_ff.fmode == `FM_CLOSED && !s_ff.bg_full
        && !s_ff.rx_flags[`F_RXF] |=> !s_ff.rx_flags[`F_RXF])
        else $error("closed filter set receive flag");
    overrun_set_a: assert property (both_full_hit_s |=> s_ff.rx_flags[`F_OVR]
        && $stable(filter_hit_index_o))
        else $error("overrun missed");
    rx_warn_a: assert property (rx_err_cnt_i >= `WARN_LIMIT |=> s_ff.rx_flags[`F_RWRN])
        else $error("warning flag missing");
    clear_blocked_a: assert property (tx_err_cnt_i > `BOFF_LIMIT
        |=> s_ff.rx_flags[`F_BOFF] && err_irq_o == |(s_ff.rx_flags[6:1] & s_ff.rx_en[6:1]))
        else $error("bus-off flag not held");
    passive_a: assert property (rx_err_cnt_i > `PASS_LIMIT && rx_clr[`F_RERR]
        |=> s_ff.rx_flags[`F_RERR])
        else $error("passive flag cleared under condition");
    lock_guard_a: assert property (wr && req_i.addr == `A_CTRL1 && !s_ff.soft_reset_lock
        |=> $stable(ctrl1_o))
        else $error("locked register changed");
    pin_recessive_a: assert property (mode_o != MODE_NORMAL |-> bus_tx_pin_o == `RECESSIVE
        && !core_clk_en_o)
        else $error("pin not recessive in low power");
    tx_follow_a: assert property (mode_o == MODE_NORMAL
        |-> bus_tx_pin_o == $past(tx_bit_i))
        else $error("pin does not follow transmit bit");
    power_down_a: assert property (cpu_stop_i |=> mode_o == MODE_POWER_DOWN && !reg_clk_en_o)
        else $error("power-down not entered");
    tx_irq_a: assert property ((s_ff.tx_empty & s_ff.tx_en) != 3'h0 |-> tx_irq_o)
        else $error("transmit interrupt missing");
    wake_gate_a: assert property ($rose(s_ff.rx_flags[`F_WAKE]) |->
        $past(s_ff.sleep_ack) && $past(s_ff.rx_en[`F_WAKE]))
        else $error("wake flag without sleep-ack and enable");

endmodule
`default_nettype wire

/* File: can_engine_model.sv */
// Far-side model: the protocol engine that hands finished frames to the block.
// Assumes one clock shared with the block; a frame starts when go_i is taken.
`timescale 1ns/100ps
`default_nettype none
module can_engine_model #(
    parameter int FRAME_LEN = 6
) (
    input  wire logic               clk_i,
    input  wire logic               rst_i,
    input  wire logic               go_i,
    input  wire logic [31:0]        id_i,
    output var can_filt_pkg::rx_frame_t frame_o,
    output logic                    busy_o,
    output logic                    tx_bit_o
);
    import can_filt_pkg::*;
    int          cnt;
    logic [31:0] id_q;
    assign busy_o = (cnt != 0);
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt      <= 0;
            id_q     <= '0;
            frame_o  <= '0;
            tx_bit_o <= 1'b1;
        end else begin
            frame_o.valid <= 1'b0;
            // Id is meaningless outside the pulse, so never let it look stable
            frame_o.id    <= ~frame_o.id;
            // Recessive between frames
            tx_bit_o      <= (cnt > 1) ? id_q[cnt] : 1'b1;
            if (go_i) begin
                cnt  <= FRAME_LEN;
                id_q <= id_i;
            end else if (cnt == 1) begin
                cnt     <= 0;
                frame_o <= '{valid: 1'b1, id: id_q};
            end else if (cnt > 1) begin
                cnt <= cnt - 1;
            end
        end
    end
endmodule
`default_nettype wire

/* File: can_filter_irq_mode_control_bench.sv */
// Self-checking bench for the filter, flag, interrupt and mode block.
// Assumes the package, the constants header and the engine model are compiled first.
`timescale 1ns/100ps
`default_nettype none
`include "can_filt_cfg.svh"
module can_filter_irq_mode_control_bench;
    import can_filt_pkg::*;
    // ----------------------------------------
    // Harness
    // ----------------------------------------
    logic clk_i, rst_i, act, stop, go, busy, txb;
    logic pin, fg_copy, core_en, reg_en, wake_irq, err_irq, rx_irq, tx_irq;
    reg_req_t    req;
    rx_frame_t   frm;
    can_mode_t   mode;
    logic [8:0]  rx_cnt, tx_cnt;
    logic [2:0]  tx_done, tx_empty;
    logic [1:0]  hit_idx;
    logic [7:0]  rd_data, ctrl1, rv;
    logic [15:0] bt;
    logic [31:0] go_id;
    int          miscompares, checks_done, cycles;

    can_filt_top dut (.clk_i(clk_i), .rst_i(rst_i), .req_i(req), .rd_data_o(rd_data),
        .frame_i(frm), .rx_err_cnt_i(rx_cnt), .tx_err_cnt_i(tx_cnt), .tx_done_i(tx_done),
        .bus_activity_i(act), .bus_busy_i(busy), .cpu_stop_i(stop), .tx_bit_i(txb),
        .bus_tx_pin_o(pin), .fg_copy_o(fg_copy), .filter_hit_index_o(hit_idx),
        .tx_empty_o(tx_empty), .ctrl1_o(ctrl1), .bit_timing_o(bt), .core_clk_en_o(core_en),
        .reg_clk_en_o(reg_en), .mode_o(mode), .wake_irq_o(wake_irq), .err_irq_o(err_irq),
        .rx_irq_o(rx_irq), .tx_irq_o(tx_irq));
    can_engine_model #(.FRAME_LEN(6)) engine (.clk_i(clk_i), .rst_i(rst_i), .go_i(go),
        .id_i(go_id), .frame_o(frm), .busy_o(busy), .tx_bit_o(txb));

    always #12.5 clk_i = ~clk_i;
    // Run needs under 2000 cycles; the ceiling leaves ample room
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            miscompares++;
            report_and_stop;
        end
    end
    // ----------------------------------------
    // Checks and bus tasks
    // ----------------------------------------
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        @(posedge clk_i);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk_i);
        req.wr <= 1'b0;
        #1;
    endtask
    task automatic rdchk(input logic [4:0] a, input logic [7:0] e);
        @(posedge clk_i);
        req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk_i);
        req.rd <= 1'b0;
        #1 rv = rd_data;
        chk("read data", rv, e);
    endtask
    task automatic set_filter(input logic [1:0] m, input logic [31:0] p, input logic [31:0] k);
        wr(`A_CTRL0, 8'h01);
        wr(`A_FMODE, {2'b00, m, 4'h0});
        for (int i = 0; i < 4; i++) begin
            wr(5'(`A_PAT0 + i), p[31-8*i -: 8]);
            wr(5'(`A_MSK0 + i), k[31-8*i -: 8]);
        end
        wr(`A_CTRL0, 8'h00);
        tick(2);
    endtask
    // Returns 1 ns after the edge at which the block takes the finished frame
    task automatic send(input logic [31:0] id);
        @(posedge clk_i);
        go <= 1'b1;
        go_id <= id;
        @(posedge clk_i);
        go <= 1'b0;
        for (int i = 0; i < 40 && frm.valid !== 1'b1; i++) @(negedge clk_i);
        tick(1);
    endtask
    task automatic try(input logic [1:0] m, input logic [31:0] p, input logic [31:0] k,
                       input logic [31:0] id, input logic hit, input logic [1:0] idx);
        set_filter(m, p, k);
        send(id);
        chk("fg_copy", fg_copy, hit);
        chk("rx_irq", rx_irq, hit);
        if (hit) chk("hit_index", hit_idx, idx);
        rdchk(`A_RXFLG, {7'h00, hit});
        wr(`A_RXFLG, 8'h01);
    endtask
    task automatic lvl(input logic [8:0] r, input logic [8:0] t, input logic [7:0] e);
        @(posedge clk_i);
        rx_cnt <= r;
        tx_cnt <= t;
        tick(2);
        rdchk(`A_RXFLG, e);
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_reset;
        chk("tx_pin", pin, 1'b1);
        chk("mode", mode, MODE_SOFT_RESET);
        chk("core_clk", core_en, 1'b0);
        chk("tx_empty", tx_empty, 3'h7);
        rdchk(`A_CTRL0, 8'h01);
    endtask
    task automatic t_lock;
        wr(`A_CTRL1, 8'h5a);
        wr(`A_BTR0, 8'h3c);
        wr(`A_BTR1, 8'hc3);
        wr(`A_CTRL0, 8'h00);
        tick(2);
        chk("mode", mode, MODE_NORMAL);
        chk("core_clk", core_en, 1'b1);
        wr(`A_CTRL1, 8'ha5);
        wr(`A_BTR0, 8'h00);
        chk("ctrl1", ctrl1, 8'h5a);
        chk("bit_timing", bt, 16'hc33c);
        @(posedge clk_i);
        rx_cnt <= 9'h05a;
        tx_cnt <= 9'h03c;
        wr(`A_RXCNT, 8'h00);
        wr(`A_TXCNT, 8'hff);
        rdchk(`A_RXCNT, 8'h5a);
        rdchk(`A_TXCNT, 8'h3c);
        lvl(9'h000, 9'h000, 8'h00);
    endtask
    task automatic t_filter;
        wr(`A_RXEN, 8'h01);
        try(`FM_SINGLE, 32'h12345678, 32'h000000ff, 32'h123456aa, 1'b1, 2'h0);
        try(`FM_SINGLE, 32'h12345678, 32'h000000ff, 32'h12345778, 1'b0, 2'h0);
        try(`FM_DUAL, 32'h12341234, 32'h00000000, 32'h1234ffff, 1'b1, 2'h0);
        try(`FM_DUAL, 32'h1234abcd, 32'h00000000, 32'habcd0000, 1'b1, 2'h1);
        try(`FM_QUAD, 32'h11223344, 32'h00000000, 32'h33000000, 1'b1, 2'h2);
        try(`FM_QUAD, 32'h11223344, 32'h00000000, 32'h44ffffff, 1'b1, 2'h3);
        try(`FM_QUAD, 32'h11223344, 32'h0f000000, 32'h15000000, 1'b1, 2'h0);
        try(`FM_CLOSED, 32'h00000000, 32'hffffffff, 32'h00000000, 1'b0, 2'h0);
    endtask
    task automatic t_overrun;
        set_filter(`FM_SINGLE, 32'h0, 32'hffffffff);
        send(32'h1);
        send(32'h2);
        send(32'h3);
        rdchk(`A_RXFLG, 8'h03);
        wr(`A_RXFLG, 8'h01);
        chk("fg_copy", fg_copy, 1'b1);
        rdchk(`A_RXFLG, 8'h03);
        wr(`A_RXFLG, 8'h03);
    endtask
    task automatic t_tx;
        wr(`A_TXEN, 8'h01);
        tick(1);
        chk("tx_irq", tx_irq, 1'b1);
        wr(`A_TXFLG, 8'h01);
        tick(1);
        chk("tx_empty", tx_empty, 3'h6);
        chk("tx_irq", tx_irq, 1'b0);
        @(posedge clk_i);
        tx_done <= 3'h1;
        @(posedge clk_i);
        tx_done <= 3'h0;
        tick(1);
        chk("tx_empty", tx_empty, 3'h7);
        chk("tx_irq", tx_irq, 1'b1);
        wr(`A_TXEN, 8'h00);
        tick(1);
        chk("tx_irq", tx_irq, 1'b0);
    endtask
    task automatic t_err;
        wr(`A_RXEN, 8'h40);
        lvl(9'd95, 9'd0, 8'h00);
        lvl(9'd96, 9'd0, 8'h40);
        chk("err_irq", err_irq, 1'b1);
        lvl(9'd127, 9'd255, 8'h68);
        lvl(9'd128, 9'd256, 8'h7c);
        wr(`A_RXFLG, 8'h7c);
        rdchk(`A_RXFLG, 8'h7c);
        lvl(9'd0, 9'd0, 8'h7c);
        wr(`A_RXFLG, 8'h7c);
        rdchk(`A_RXFLG, 8'h00);
        chk("err_irq", err_irq, 1'b0);
    endtask
    task automatic t_sleep;
        wr(`A_RXEN, 8'h80);
        @(posedge clk_i);
        act <= 1'b1;
        @(posedge clk_i);
        act <= 1'b0;
        tick(2);
        chk("wake_irq", wake_irq, 1'b0);
        wr(`A_CTRL0, 8'h02);
        tick(3);
        chk("mode", mode, MODE_SLEEP);
        chk("core_clk", core_en, 1'b0);
        chk("reg_clk", reg_en, 1'b1);
        chk("tx_pin", pin, 1'b1);
        rdchk(`A_CTRL0, 8'h06);
        @(posedge clk_i);
        act <= 1'b1;
        @(posedge clk_i);
        act <= 1'b0;
        tick(2);
        chk("wake_irq", wake_irq, 1'b1);
        chk("mode", mode, MODE_NORMAL);
        @(posedge clk_i);
        stop <= 1'b1;
        tick(2);
        chk("mode", mode, MODE_POWER_DOWN);
        chk("reg_clk", reg_en, 1'b0);
        chk("tx_pin", pin, 1'b1);
        rdchk(`A_RXEN, 8'h00);
    endtask
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    task automatic report_and_stop;
        $display("Comparisons %0d, mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    initial begin
        clk_i = 1'b0;
        rst_i = 1'b1;
        req = '0;
        {rx_cnt, tx_cnt, tx_done, act, stop, go, go_id} = '0;
        {miscompares, checks_done, cycles} = '0;
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        tick(1);
        t_reset;
        t_lock;
        t_filter;
        t_overrun;
        t_tx;
        t_err;
        t_sleep;
        report_and_stop;
    end
endmodule
`default_nettype wire
